// ===== bmu_pkg.sv
// shared types and constants for the bit manipulation unit
package bmu_pkg;

  localparam int BMU_BYTE_W = 8;
  localparam int BMU_BITNUM_W = 3;
  localparam int BMU_ADDR_W = 16;

  localparam logic [7:0] BMU_BYTE_ZERO = 8'h00;
  localparam logic [7:0] BMU_LSB_MASK = 8'h01;
  localparam logic [2:0] BMU_BITNUM_ZERO = 3'h0;
  localparam logic [15:0] BMU_ADDR_ZERO = 16'h0000;

  typedef enum logic [3:0] {
    BMU_SET_BIT_OP,
    BMU_CLEAR_BIT_OP,
    BMU_INVERT_BIT_OP,
    BMU_TEST_BIT_TO_ZERO_FLAG,
    BMU_AND_BIT_INTO_CARRY,
    BMU_AND_INVERTED_BIT_INTO_CARRY,
    BMU_OR_BIT_INTO_CARRY,
    BMU_OR_INVERTED_BIT_INTO_CARRY,
    BMU_XOR_BIT_INTO_CARRY,
    BMU_XOR_INVERTED_BIT_INTO_CARRY,
    BMU_LOAD_BIT_TO_CARRY,
    BMU_LOAD_INVERTED_BIT_TO_CARRY,
    BMU_STORE_CARRY_TO_BIT,
    BMU_STORE_INVERTED_CARRY_TO_BIT
  } bmu_op_t;

  typedef enum logic {
    BMU_SRC_IMM,
    BMU_SRC_REG
  } bmu_src_t;

  typedef enum logic {
    BMU_DST_REG,
    BMU_DST_MEM
  } bmu_dst_t;

  typedef struct packed {
    bmu_op_t op;
    bmu_src_t src;
    logic [2:0] imm_bit;
    logic [7:0] index_reg;
    bmu_dst_t dst;
    logic [7:0] reg_data;
    logic [15:0] addr;
    logic carry;
  } bmu_req_t;

  typedef struct packed {
    logic byte_we;
    logic carry_we;
    logic zero_we;
    logic [7:0] byte_val;
    logic carry;
    logic zero;
  } bmu_res_t;

endpackage : bmu_pkg

// ===== bmu_bit_decode.sv
// bit number selection and one-hot byte mask
`timescale 1ns/1ps
module bmu_bit_decode (
  // selection inputs
  input wire bmu_pkg::bmu_src_t src,
  input wire logic [2:0] imm_bit,
  input wire logic [7:0] index_reg,
  // decoded outputs
  output logic [2:0] bit_num,
  output logic [7:0] mask
);

  always_comb begin
    if (src == bmu_pkg::BMU_SRC_REG) begin
      bit_num = index_reg[bmu_pkg::BMU_BITNUM_W-1:0];
    end else begin
      bit_num = imm_bit;
    end
  end

  // bit 0 is the lsb, bit 7 the msb
  assign mask = bmu_pkg::BMU_LSB_MASK << bit_num;

endmodule : bmu_bit_decode

// ===== bmu_bit_alu.sv
// combinational bit operation core
`timescale 1ns/1ps
module bmu_bit_alu (
  // operands
  input wire bmu_pkg::bmu_op_t op,
  input wire logic [7:0] operand,
  input wire logic [7:0] mask,
  input wire logic carry,
  // results
  output bmu_pkg::bmu_res_t res,
  output logic bad_op
);

  logic sel_bit;

  assign sel_bit = |(operand & mask);

  always_comb begin
    res = '0;
    res.byte_val = operand;
    res.carry = carry;
    bad_op = 1'h0;
    case (op)
      bmu_pkg::BMU_SET_BIT_OP: begin
        res.byte_val = operand | mask;
        res.byte_we = 1'h1;
      end
      bmu_pkg::BMU_CLEAR_BIT_OP: begin
        res.byte_val = operand & ~mask;
        res.byte_we = 1'h1;
      end
      bmu_pkg::BMU_INVERT_BIT_OP: begin
        res.byte_val = operand ^ mask;
        res.byte_we = 1'h1;
      end
      bmu_pkg::BMU_TEST_BIT_TO_ZERO_FLAG: begin
        res.zero = ~sel_bit;
        res.zero_we = 1'h1;
      end
      bmu_pkg::BMU_AND_BIT_INTO_CARRY: begin
        res.carry = carry & sel_bit;
        res.carry_we = 1'h1;
      end
      bmu_pkg::BMU_AND_INVERTED_BIT_INTO_CARRY: begin
        res.carry = carry & ~sel_bit;
        res.carry_we = 1'h1;
      end
      bmu_pkg::BMU_OR_BIT_INTO_CARRY: begin
        res.carry = carry | sel_bit;
        res.carry_we = 1'h1;
      end
      bmu_pkg::BMU_OR_INVERTED_BIT_INTO_CARRY: begin
        res.carry = carry | ~sel_bit;
        res.carry_we = 1'h1;
      end
      bmu_pkg::BMU_XOR_BIT_INTO_CARRY: begin
        res.carry = carry ^ sel_bit;
        res.carry_we = 1'h1;
      end
      bmu_pkg::BMU_XOR_INVERTED_BIT_INTO_CARRY: begin
        res.carry = carry ^ ~sel_bit;
        res.carry_we = 1'h1;
      end
      bmu_pkg::BMU_LOAD_BIT_TO_CARRY: begin
        res.carry = sel_bit;
        res.carry_we = 1'h1;
      end
      bmu_pkg::BMU_LOAD_INVERTED_BIT_TO_CARRY: begin
        res.carry = ~sel_bit;
        res.carry_we = 1'h1;
      end
      bmu_pkg::BMU_STORE_CARRY_TO_BIT: begin
        res.byte_val = carry ? (operand | mask) : (operand & ~mask);
        res.byte_we = 1'h1;
      end
      bmu_pkg::BMU_STORE_INVERTED_CARRY_TO_BIT: begin
        res.byte_val = carry ? (operand & ~mask) : (operand | mask);
        res.byte_we = 1'h1;
      end
      default: begin
        bad_op = 1'h1;
      end
    endcase
  end

endmodule : bmu_bit_alu

// ===== bmu_unit.sv
// bit manipulation unit: request sequencing, memory read-modify-write, flag and register write-back
`timescale 1ns/1ps
// How it works
// - set-bit forces the selected destination bit to one.
// - clear-bit forces the selected destination bit to zero.
// - invert-bit replaces the selected destination bit with its complement.
// - test-bit loads zero flag with inverse of selected bit; operand untouched.
// - bit number comes from 3-bit immediate or low three register bits.
// - bit-AND writes carry with carry AND selected bit.
// - inverted bit-AND writes carry with carry AND inverted selected bit.
// - bit-OR writes carry with carry OR selected bit.
// - inverted bit-OR writes carry with carry OR inverted selected bit.
// - bit-XOR writes carry with carry XOR selected bit.
// - inverted bit-XOR writes carry with carry XOR inverted selected bit.
// - bit-load copies the selected bit into carry.
// - inverted bit-load copies the inverted selected bit into carry.
// - bit-store writes carry into the selected destination bit.
// - inverted bit-store writes inverted carry into the selected destination bit.
// - inverting AND, OR, XOR, load, store take bit number from immediate only.
module bmu_unit (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // request
  input wire logic REQ_VALID,
  input wire bmu_pkg::bmu_req_t REQ,
  output logic REQ_READY,
  // completion
  output logic DONE,
  output logic ILLEGAL,
  // memory port
  output logic MEM_RD,
  output logic MEM_WR,
  output logic [15:0] MEM_ADDR,
  output logic [7:0] MEM_WDATA,
  input wire logic [7:0] MEM_RDATA,
  input wire logic MEM_ACK,
  // general register write-back
  output logic REG_WE,
  output logic [7:0] REG_WDATA,
  // flag write-back
  output logic CARRY_WE,
  output logic CARRY_OUT,
  output logic ZERO_WE,
  output logic ZERO_OUT
);

  typedef enum logic [1:0] {
    BMU_IDLE,
    BMU_MEM_READ,
    BMU_EXECUTE,
    BMU_MEM_WRITE
  } bmu_state_t;

  bmu_state_t state_reg;
  bmu_state_t state_next;
  bmu_pkg::bmu_req_t req_reg;
  logic [7:0] operand_reg;
  logic [2:0] bit_num;
  logic [7:0] mask;
  bmu_pkg::bmu_res_t res;
  logic bad_op;
  logic src_refused;
  logic req_take;
  logic req_bad;
  logic mem_done;
  logic good_take;
  logic bad_take;
  logic mem_take;
  logic in_execute;
  logic exec_last;
  logic exec_byte_mem;
  logic exec_byte_reg;

  bmu_bit_decode u_decode (
    .src(req_reg.src),
    .imm_bit(req_reg.imm_bit),
    .index_reg(req_reg.index_reg),
    .bit_num(bit_num),
    .mask(mask)
  );

  bmu_bit_alu u_alu (
    .op(req_reg.op),
    .operand(operand_reg),
    .mask(mask),
    .carry(req_reg.carry),
    .res(res),
    .bad_op(bad_op)
  );

  // inverting variants have no register bit-number form
  always_comb begin
    src_refused = 1'h0;
    if (REQ.src == bmu_pkg::BMU_SRC_REG) begin
      case (REQ.op)
        bmu_pkg::BMU_AND_INVERTED_BIT_INTO_CARRY,
        bmu_pkg::BMU_OR_INVERTED_BIT_INTO_CARRY,
        bmu_pkg::BMU_XOR_INVERTED_BIT_INTO_CARRY,
        bmu_pkg::BMU_LOAD_INVERTED_BIT_TO_CARRY,
        bmu_pkg::BMU_STORE_INVERTED_CARRY_TO_BIT: src_refused = 1'h1;
        default: src_refused = 1'h0;
      endcase
    end
  end

  assign req_take = REQ_VALID && REQ_READY;
  // an unused opcode is refused just like a bad source
  assign req_bad = src_refused || (REQ.op > bmu_pkg::BMU_STORE_INVERTED_CARRY_TO_BIT);
  assign mem_done = MEM_ACK && (MEM_RD || MEM_WR);

  // qualified strobes shared by the update blocks
  assign good_take = req_take && !req_bad;
  assign bad_take = req_take && req_bad;
  assign mem_take = good_take && REQ.dst == bmu_pkg::BMU_DST_MEM;
  assign in_execute = state_reg == BMU_EXECUTE;
  assign exec_last = in_execute && state_next == BMU_IDLE;
  assign exec_byte_mem = in_execute && res.byte_we && req_reg.dst == bmu_pkg::BMU_DST_MEM;
  assign exec_byte_reg = in_execute && res.byte_we && req_reg.dst == bmu_pkg::BMU_DST_REG;

  // memory targets detour through a read, and modifying ops through a write
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      BMU_IDLE: begin
        if (req_take && !req_bad) begin
          if (REQ.dst == bmu_pkg::BMU_DST_MEM) begin
            state_next = BMU_MEM_READ;
          end else begin
            state_next = BMU_EXECUTE;
          end
        end
      end
      BMU_MEM_READ: begin
        if (MEM_ACK && MEM_RD) begin
          state_next = BMU_EXECUTE;
        end
      end
      BMU_EXECUTE: begin
        if (res.byte_we && req_reg.dst == bmu_pkg::BMU_DST_MEM) begin
          state_next = BMU_MEM_WRITE;
        end else begin
          state_next = BMU_IDLE;
        end
      end
      BMU_MEM_WRITE: begin
        if (MEM_ACK && MEM_WR) begin
          state_next = BMU_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= BMU_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // request capture
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      req_reg <= '0;
    end else if (req_take && !req_bad) begin
      req_reg <= REQ;
    end
  end

  // operand byte: register value directly, memory value on read ack
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      operand_reg <= bmu_pkg::BMU_BYTE_ZERO;
    end else if (req_take && !req_bad && REQ.dst == bmu_pkg::BMU_DST_REG) begin
      operand_reg <= REQ.reg_data;
    end else if (state_reg == BMU_MEM_READ && MEM_ACK && MEM_RD) begin
      operand_reg <= MEM_RDATA;
    end
  end

  // ready only while idle, dropped the cycle a legal request is taken; refused requests leave it high
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      REQ_READY <= 1'h0;
    end else begin
      REQ_READY <= (state_next == BMU_IDLE) && !good_take;
    end
  end

  // memory read strobe held until ack
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      MEM_RD <= 1'h0;
    end else if (mem_take) begin
      MEM_RD <= 1'h1;
    end else if (MEM_ACK) begin
      MEM_RD <= 1'h0;
    end
  end

  // memory write strobe held until ack
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      MEM_WR <= 1'h0;
    end else if (exec_byte_mem) begin
      MEM_WR <= 1'h1;
    end else if (MEM_ACK) begin
      MEM_WR <= 1'h0;
    end
  end

  // byte written back whole, steady for the whole strobe
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      MEM_WDATA <= bmu_pkg::BMU_BYTE_ZERO;
    end else if (exec_byte_mem) begin
      MEM_WDATA <= res.byte_val;
    end
  end

  // address captured once at take, shared by both strobes
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      MEM_ADDR <= bmu_pkg::BMU_ADDR_ZERO;
    end else if (req_take && !req_bad) begin
      MEM_ADDR <= REQ.addr;
    end
  end

  // register write-back pulse
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      REG_WE <= 1'h0;
    end else begin
      REG_WE <= exec_byte_reg;
    end
  end

  // data holds so the register file may sample it late
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      REG_WDATA <= bmu_pkg::BMU_BYTE_ZERO;
    end else if (in_execute && res.byte_we) begin
      REG_WDATA <= res.byte_val;
    end
  end

  // flags are pulsed the cycle after execute, in the same cycle as done on both register and memory targets
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      CARRY_WE <= 1'h0;
    end else begin
      CARRY_WE <= in_execute && res.carry_we && !bad_op;
    end
  end

  // carry value holds between pulses
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      CARRY_OUT <= 1'h0;
    end else if (in_execute && res.carry_we) begin
      CARRY_OUT <= res.carry;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ZERO_WE <= 1'h0;
    end else begin
      ZERO_WE <= in_execute && res.zero_we && !bad_op;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ZERO_OUT <= 1'h0;
    end else if (in_execute && res.zero_we) begin
      ZERO_OUT <= res.zero;
    end
  end

  // completion and refusal pulses
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ILLEGAL <= 1'h0;
    end else begin
      ILLEGAL <= bad_take;
    end
  end

  // refused requests finish at once, so the caller never waits on them
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      DONE <= 1'h0;
    end else begin
      DONE <= bad_take || exec_last || (state_reg == BMU_MEM_WRITE && mem_done);
    end
  end

endmodule : bmu_unit

// ===== bmu_unit_chk.sv
// port assertions for the bit manipulation unit
`timescale 1ns/1ps
module bmu_unit_chk (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // request
  input wire logic REQ_VALID,
  input wire bmu_pkg::bmu_req_t REQ,
  input wire logic REQ_READY,
  // completion
  input wire logic DONE,
  input wire logic ILLEGAL,
  // memory port
  input wire logic MEM_RD,
  input wire logic MEM_WR,
  input wire logic [15:0] MEM_ADDR,
  input wire logic MEM_ACK,
  // write-back
  input wire logic REG_WE,
  input wire logic [7:0] REG_WDATA,
  input wire logic CARRY_WE,
  input wire logic CARRY_OUT,
  input wire logic ZERO_WE,
  input wire logic ZERO_OUT
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  bmu_pkg::bmu_req_t q_reg;
  logic take, bad, rd, bit_v;
  logic [2:0] bn;
  logic [7:0] m;
  assign take = REQ_VALID && REQ_READY;
  assign bad = REQ.op > 4'hD || (REQ.op[0] && REQ.op > 4'h4 && REQ.src == bmu_pkg::BMU_SRC_REG);
  assign bn = q_reg.src == bmu_pkg::BMU_SRC_REG ? q_reg.index_reg[2:0] : q_reg.imm_bit;
  assign m = 8'h01 << bn;
  assign bit_v = q_reg.reg_data[bn];
  assign rd = DONE && !ILLEGAL && q_reg.dst == bmu_pkg::BMU_DST_REG;
  // register-target results show two edges after the take, so keep the request
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      q_reg <= '0;
    end else if (take) begin
      q_reg <= REQ;
    end
  end
  chk_refused_quiet: assert property (
    take && bad |=> DONE && ILLEGAL && REQ_READY && !REG_WE && !CARRY_WE && !ZERO_WE && !MEM_RD)
    else $error("refused request had side effects");
  chk_reg_timing: assert property (
    take && !bad && REQ.dst == bmu_pkg::BMU_DST_REG |=> !REQ_READY && !MEM_RD ##1 DONE && !MEM_WR)
    else $error("register target late or touched memory");
  chk_set_bit: assert property (
    rd && q_reg.op == bmu_pkg::BMU_SET_BIT_OP |-> REG_WE && REG_WDATA == (q_reg.reg_data | m))
    else $error("set result wrong");
  chk_clear_bit: assert property (
    rd && q_reg.op == bmu_pkg::BMU_CLEAR_BIT_OP |-> REG_WE && REG_WDATA == (q_reg.reg_data & ~m))
    else $error("clear result wrong");
  chk_test_zero: assert property (
    rd && q_reg.op == bmu_pkg::BMU_TEST_BIT_TO_ZERO_FLAG |-> ZERO_WE && !REG_WE && ZERO_OUT == !bit_v)
    else $error("test flag wrong");
  chk_load_carry: assert property (
    rd && q_reg.op == bmu_pkg::BMU_LOAD_BIT_TO_CARRY |-> CARRY_WE && !REG_WE && CARRY_OUT == bit_v)
    else $error("load carry wrong");
  chk_store_bit: assert property (
    rd && q_reg.op == bmu_pkg::BMU_STORE_CARRY_TO_BIT |->
      REG_WE && REG_WDATA == (q_reg.carry ? q_reg.reg_data | m : q_reg.reg_data & ~m))
    else $error("store result wrong");
  chk_read_hold: assert property (
    MEM_RD && !MEM_ACK |=> MEM_RD && $stable(MEM_ADDR))
    else $error("read strobe dropped early");
  cov_refused: cover property (take && bad);
  cov_mem_write: cover property (MEM_WR && MEM_ACK);
  cov_reg_done: cover property (rd && REG_WE);
endmodule : bmu_unit_chk

bind bmu_unit bmu_unit_chk u_chk (.CLK, .RSTN, .REQ_VALID, .REQ, .REQ_READY, .DONE, .ILLEGAL, .MEM_RD,
  .MEM_WR, .MEM_ADDR, .MEM_ACK, .REG_WE, .REG_WDATA, .CARRY_WE, .CARRY_OUT, .ZERO_WE, .ZERO_OUT);

// ===== testbench.sv
// self-checking bench for the bit manipulation unit
`timescale 1ns/1ps
module testbench;
  logic CLK, RSTN, REQ_VALID, MEM_ACK, REQ_READY, DONE, ILLEGAL, MEM_RD, MEM_WR;
  logic REG_WE, CARRY_WE, CARRY_OUT, ZERO_WE, ZERO_OUT;
  logic [15:0] MEM_ADDR;
  logic [7:0] MEM_RDATA, MEM_WDATA, REG_WDATA, mem_b, wr_b;
  logic [63:0] rv;
  logic [7:0] wr_q[$];
  bmu_pkg::bmu_req_t req_r;
  int n_fail, n_compared, cyc, t, i;
  bmu_unit uut (.CLK, .RSTN, .REQ_VALID, .REQ(req_r), .REQ_READY, .DONE, .ILLEGAL, .MEM_RD, .MEM_WR,
    .MEM_ADDR, .MEM_WDATA, .MEM_RDATA, .MEM_ACK, .REG_WE, .REG_WDATA, .CARRY_WE, .CARRY_OUT,
    .ZERO_WE, .ZERO_OUT);
  initial begin
    CLK = 0;
    forever #4 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task close_out;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  // model first, then one request with a slow memory
  task run_one(input bmu_pkg::bmu_req_t r);
    int opd, bn, b, c, v, nc, z, ill, wr, k;
    opd = r.dst == bmu_pkg::BMU_DST_MEM ? mem_b : r.reg_data;
    bn = r.src == bmu_pkg::BMU_SRC_REG ? r.index_reg % 8 : r.imm_bit;
    b = opd >> bn & 1;
    c = r.carry;
    v = -1;
    nc = -1;
    z = -1;
    case (int'(r.op))
      0: v = 1;
      1: v = 0;
      2: v = !b;
      3: z = !b;
      4: nc = c & b;
      5: nc = c & !b;
      6: nc = c | b;
      7: nc = c | !b;
      8: nc = c ^ b;
      9: nc = c ^ !b;
      10: nc = b;
      11: nc = !b;
      12: v = c;
      13: v = !c;
      default: v = -1;
    endcase
    ill = r.op > 13 || (r.op % 2 && r.op > 4 && r.src == bmu_pkg::BMU_SRC_REG);
    if (ill) begin
      v = -1;
      nc = -1;
    end
    req_r = r;
    REQ_VALID = 1;
    while (!REQ_READY) begin
      @(posedge CLK);
      #1;
    end
    @(posedge CLK);
    #1;
    REQ_VALID = 0;
    wr_q.delete();
    for (k = 0; k < 60 && !DONE; k++) begin
      if (MEM_ACK) MEM_ACK = 0;
      else if ((MEM_RD || MEM_WR) && $urandom % 3 == 0) begin
        MEM_ACK = 1;
        MEM_RDATA = mem_b;
        check("mem address", MEM_ADDR, r.addr);
        if (MEM_WR) begin
          wr_q.push_back(MEM_WDATA);
        end
      end
      @(posedge CLK);
      #1;
      MEM_RDATA = ~mem_b;
    end
    MEM_ACK = 0;
    wr = wr_q.size();
    if (wr > 0) wr_b = wr_q.pop_front();
    check("done", DONE, 1);
    check("refused", ILLEGAL, ill);
    check("byte write", r.dst == bmu_pkg::BMU_DST_MEM ? wr : REG_WE, v >= 0);
    if (v >= 0) check("byte", r.dst ? wr_b : REG_WDATA, (opd & ~(1 << bn)) | (v << bn));
    check("carry write", CARRY_WE, nc >= 0);
    if (nc >= 0) check("carry", CARRY_OUT, nc);
    check("zero write", ZERO_WE, z >= 0);
    if (z >= 0) check("zero", ZERO_OUT, z);
  endtask : run_one
  initial begin
    RSTN = 0;
    REQ_VALID = 0;
    req_r = '0;
    MEM_ACK = 0;
    MEM_RDATA = 8'h00;
    void'($urandom(67));
    repeat (4) @(posedge CLK);
    #1;
    RSTN = 1;
    @(posedge CLK);
    #1;
    // register targets first, then memory read-modify-write
    for (t = 0; t < 2; t++) begin
      for (i = 0; i < 200; i++) begin
        rv = {$urandom, $urandom};
        req_r = rv[41:0];
        req_r.op = bmu_pkg::bmu_op_t'(i % 16);
        req_r.dst = bmu_pkg::bmu_dst_t'(t);
        mem_b = $urandom;
        run_one(req_r);
      end
      $display("test %0d ended, mismatches %0d", t, n_fail);
    end
    close_out();
  end
endmodule : testbench
